// ==== bench/ssr_ctrl_model.sv ====
// Purpose: Bus controller model that sends decoded commands and serial polls.
// Assumes: The core takes a request on the edge after it is raised.
// Notes: Released lines carry the inverse of the last value, never a stale one.
`timescale 1ns/100ps
`default_nettype none
module ssr_ctrl_model (
  // Clock
  input wire logic mclk,
  // Requests
  output logic cmd_valid,
  output logic [4:0] cmd_code,
  output logic [15:0] cmd_data,
  output logic serial_poll,
  // Answers
  input wire logic resp_valid,
  input wire logic [15:0] resp_data,
  input wire logic [7:0] poll_data
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 5'h1f;
    cmd_data = 16'hffff;
    serial_poll = 1'b0;
  end

  // One command held over its taking edge, answer read just after that same edge
  task automatic send(input logic [4:0] code, input logic [15:0] data, output logic ok, output logic [15:0] rd);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_data = data;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~code; // Hides the stale code
    cmd_data = ~data;
    ok = resp_valid;
    rd = resp_data;
  endtask : send

  // Serial poll held over its taking edge
  task automatic poll(output logic [7:0] pd);
    @(posedge mclk);
    #1;
    serial_poll = 1'b1;
    @(posedge mclk);
    #1;
    serial_poll = 1'b0;
    pd = poll_data;
  endtask : poll
endmodule : ssr_ctrl_model
`default_nettype wire

// ==== bench/ssr_status_core_assertions.sv ====
// Purpose: Port-level checks on the status core.
// Assumes: One clock, reset asynchronous and active high.
// Notes: Bound into every core instance.
`timescale 1ns/100ps
`default_nettype none
module ssr_status_core_assertions #(
  parameter int unsigned NUM_KEYS = 16
) (
  // Clock, reset and inputs
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_code,
  input wire logic serial_poll,
  input wire logic trig_mode,
  input wire logic first_reading,
  input wire logic fetch_moved,
  input wire logic msg_loaded,
  input wire logic msg_read,
  input wire logic [NUM_KEYS-1:0] keys_in,
  // Outputs
  input wire logic resp_valid,
  input wire logic poll_valid,
  input wire logic [7:0] status_byte,
  input wire logic srq_o,
  input wire logic srq_oe,
  input wire logic output_message_pending_flag,
  input wire logic [NUM_KEYS-1:0] keys_out,
  input wire logic remote_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Query codes that must be answered
  logic is_q;
  assign is_q = cmd_valid && (cmd_code inside {5'h04, 5'h06, 5'h08, 5'h09, 5'h0b, 5'h0d});

  sequence s_poll_done;
    poll_valid && !status_byte[6] && !srq_oe;
  endsequence
  sequence s_buf_add;
    msg_loaded && !msg_read && !cmd_valid;
  endsequence

  property p_unused_zero;
    status_byte[2:0] == 3'h0 && !status_byte[7];
  endproperty
  property p_srq_line;
    srq_oe == status_byte[6] && !srq_o;
  endproperty
  property p_poll;
    serial_poll |-> ##1 s_poll_done;
  endproperty
  property p_poll_only;
    !serial_poll |=> !poll_valid;
  endproperty
  property p_answer;
    is_q |=> resp_valid;
  endproperty
  property p_no_answer;
    !is_q |=> !resp_valid;
  endproperty
  property p_msg_bit;
    output_message_pending_flag == status_byte[4];
  endproperty
  property p_buf_add;
    s_buf_add |=> ##1 output_message_pending_flag;
  endproperty
  property p_stored;
    trig_mode && first_reading && !fetch_moved && !msg_loaded && !cmd_valid && !output_message_pending_flag
      |=> ##1 !output_message_pending_flag;
  endproperty
  property p_remote;
    remote_mode && $past(remote_mode) |-> keys_out == '0;
  endproperty
  property p_local;
    !remote_mode && !$past(remote_mode) && !$past(rst) |-> keys_out == $past(keys_in);
  endproperty

  a_unused_zero: assert property (p_unused_zero) else $error("Unused status bit set");
  a_srq_line: assert property (p_srq_line) else $error("Service line differs from bit 6");
  a_poll: assert property (p_poll) else $error("Poll answer or request clear missing");
  a_poll_only: assert property (p_poll_only) else $error("Poll answer without poll");
  a_answer: assert property (p_answer) else $error("Query not answered");
  a_no_answer: assert property (p_no_answer) else $error("Answer without query");
  a_msg_bit: assert property (p_msg_bit) else $error("Message flag differs from bit 4");
  a_buf_add: assert property (p_buf_add) else $error("Message flag not set");
  a_stored: assert property (p_stored) else $error("Stored mode flag set early");
  a_remote: assert property (p_remote) else $error("Key passed in remote mode");
  a_local: assert property (p_local) else $error("Key lost in local mode");
endmodule : ssr_status_core_assertions

bind ssr_status_core ssr_status_core_assertions #(.NUM_KEYS(NUM_KEYS)) u_chk (
  .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .serial_poll(serial_poll),
  .trig_mode(trig_mode), .first_reading(first_reading), .fetch_moved(fetch_moved), .msg_loaded(msg_loaded),
  .msg_read(msg_read), .keys_in(keys_in), .resp_valid(resp_valid), .poll_valid(poll_valid),
  .status_byte(status_byte), .srq_o(srq_o), .srq_oe(srq_oe),
  .output_message_pending_flag(output_message_pending_flag), .keys_out(keys_out), .remote_mode(remote_mode)
);
`default_nettype wire

// ==== bench/status_reporting_srq_logic_tb.sv ====
// Purpose: Self-checking bench for the status core.
// Assumes: Controller model sends commands; events are pulsed here.
// Notes: Fixed waits follow the one-cycle status update of the core.
`timescale 1ns/100ps
`default_nettype none
module status_reporting_srq_logic_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] ev = '0; // power, opc, qry, dev, exe, cmd, first, fetch, load, read
  logic [15:0] qc = '0;
  logic tm = 1'b0;
  logic [15:0] keys = '0;
  logic lkey = 1'b0;
  logic cv, ps, rv, pv, srq_o, srq_oe, mpf, lko, rem;
  logic [4:0] cc;
  logic [15:0] cd, rd, ko;
  logic [7:0] pd, sb, p;
  int fail_count = 0;
  int total_checks = 0;
  int esr_pos[5] = '{0, 2, 3, 4, 5};
  int ques_pos[6] = '{0, 1, 9, 11, 12, 15};

  // 10 MHz clock
  always #50 mclk = ~mclk;

  ssr_ctrl_model ctrl (.mclk(mclk), .cmd_valid(cv), .cmd_code(cc), .cmd_data(cd), .serial_poll(ps),
    .resp_valid(rv), .resp_data(rd), .poll_data(pd));
  ssr_status_core dut (.mclk(mclk), .rst(rst), .power_on_evt(ev[9]), .cmd_valid(cv), .cmd_code(cc),
    .cmd_data(cd), .serial_poll(ps), .opc_done(ev[8]), .query_err(ev[7]), .device_err(ev[6]),
    .exec_err(ev[5]), .command_err(ev[4]), .ques_cond(qc), .trig_mode(tm), .first_reading(ev[3]),
    .fetch_moved(ev[2]), .msg_loaded(ev[1]), .msg_read(ev[0]), .keys_in(keys), .local_key(lkey),
    .resp_valid(rv), .resp_data(rd), .poll_valid(pv), .poll_data(pd), .status_byte(sb), .srq_o(srq_o),
    .srq_oe(srq_oe), .output_message_pending_flag(mpf), .keys_out(ko), .local_key_out(lko), .remote_mode(rem));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  // One-cycle event pulse
  task automatic pulse(input logic [9:0] e, input logic [15:0] q);
    @(posedge mclk);
    #1;
    ev = e;
    qc = q;
    @(posedge mclk);
    #1;
    ev = '0;
    qc = '0;
  endtask : pulse

  task automatic query(input logic [4:0] code, input logic [15:0] exp);
    logic ok;
    logic [15:0] r;
    ctrl.send(code, 16'h0, ok, r);
    chk({15'h0, ok}, 16'h1);
    chk(r, exp);
  endtask : query

  // Writes and plain commands carry no answer
  task automatic wr(input logic [4:0] code, input logic [15:0] data);
    logic ok;
    logic [15:0] r;
    ctrl.send(code, data, ok, r);
    chk({15'h0, ok}, 16'h0);
  endtask : wr

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // Run limit
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    summarize();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    query(ssr_pkg::CMD_ESR_Q, 16'h0080);
    query(ssr_pkg::CMD_ESR_Q, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      pulse(10'h100 >> i, 16'h0);
      query(ssr_pkg::CMD_ESR_Q, 16'h1 << esr_pos[i]);
    end
    for (int i = 0; i < 6; i++) begin
      pulse(10'h0, 16'h1 << ques_pos[i]);
      query(ssr_pkg::CMD_QEV_Q, ques_pos[i] == 15 ? 16'h0 : 16'h1 << ques_pos[i]);
    end
    query(ssr_pkg::CMD_ESR_Q, 16'h0008);
    pulse(10'h1f0, 16'hffff);
    query(ssr_pkg::CMD_ESR_Q, 16'h003d);
    query(ssr_pkg::CMD_QEV_Q, 16'h1a03);
    // Service request setup, poll and clears
    wr(ssr_pkg::CMD_DCL, 16'h0);
    wr(ssr_pkg::CMD_CLS, 16'h0);
    wr(ssr_pkg::CMD_ESE_W, 16'h0001);
    wr(ssr_pkg::CMD_SRE_W, 16'h0020);
    query(ssr_pkg::CMD_ESE_Q, 16'h0001);
    query(ssr_pkg::CMD_ESE_Q, 16'h0001);
    pulse(10'h100, 16'h0);
    idle(2);
    chk({8'h0, sb}, 16'h0060);
    chk({15'h0, srq_oe}, 16'h1);
    wr(ssr_pkg::CMD_RST, 16'h0);
    query(ssr_pkg::CMD_STB_Q, 16'h0060);
    idle(1);
    chk({8'h0, sb}, 16'h0060);
    ctrl.poll(p);
    chk({15'h0, pv}, 16'h1);
    chk({8'h0, p}, 16'h0060);
    chk({8'h0, sb}, 16'h0020);
    query(ssr_pkg::CMD_ESR_Q, 16'h0001);
    idle(1);
    chk({8'h0, sb}, 16'h0000);
    pulse(10'h100, 16'h0);
    idle(2);
    chk({8'h0, sb}, 16'h0060);
    query(ssr_pkg::CMD_ESR_Q, 16'h0001);
    idle(1);
    chk({7'h0, srq_oe, sb}, 16'h0000);
    wr(ssr_pkg::CMD_CLS, 16'h0);
    query(ssr_pkg::CMD_ESE_Q, 16'h0001);
    // Questionable summary and preset
    wr(ssr_pkg::CMD_QEN_W, 16'h1000);
    wr(ssr_pkg::CMD_SRE_W, 16'h0008);
    pulse(10'h100, 16'h1000);
    idle(2);
    chk({8'h0, sb}, 16'h0068);
    query(ssr_pkg::CMD_QEV_Q, 16'h1000);
    idle(2);
    chk({8'h0, sb}, 16'h0020);
    wr(ssr_pkg::CMD_CLS, 16'h0);
    idle(1);
    chk({8'h0, sb}, 16'h0000);
    query(ssr_pkg::CMD_QEN_Q, 16'h1000);
    wr(ssr_pkg::CMD_PRESET, 16'h0);
    query(ssr_pkg::CMD_QEN_Q, 16'h0000);
    // Power-on clear setting
    wr(ssr_pkg::CMD_SRE_W, 16'h0020);
    wr(ssr_pkg::CMD_PSC_W, 16'h0000);
    pulse(10'h200, 16'h0);
    query(ssr_pkg::CMD_SRE_Q, 16'h0020);
    wr(ssr_pkg::CMD_PSC_W, 16'h0001);
    pulse(10'h200, 16'h0);
    query(ssr_pkg::CMD_SRE_Q, 16'h0000);
    wr(ssr_pkg::CMD_SRE_W, 16'h0020);
    wr(ssr_pkg::CMD_SRE_W, 16'h0000);
    query(ssr_pkg::CMD_SRE_Q, 16'h0000);
    query(ssr_pkg::CMD_ESR_Q, 16'h0080);
    // Message flag in both trigger modes
    pulse(10'h008, 16'h0);
    idle(1);
    chk({15'h0, sb[4]}, 16'h1);
    pulse(10'h002, 16'h0);
    pulse(10'h001, 16'h0);
    idle(1);
    chk({15'h0, mpf}, 16'h1);
    pulse(10'h001, 16'h0);
    idle(1);
    chk({15'h0, mpf}, 16'h0);
    tm = 1'b1;
    pulse(10'h008, 16'h0);
    idle(1);
    chk({15'h0, mpf}, 16'h0);
    pulse(10'h004, 16'h0);
    idle(1);
    chk({15'h0, mpf}, 16'h1);
    pulse(10'h001, 16'h0);
    pulse(10'h001, 16'h0);
    query(ssr_pkg::CMD_ESR_Q, 16'h0004);
    // Front panel lockout
    keys = 16'ha5a5;
    idle(2);
    chk(ko, 16'ha5a5);
    wr(ssr_pkg::CMD_REMOTE, 16'h0);
    idle(2);
    chk({rem, ko[14:0]}, 16'h8000);
    lkey = 1'b1;
    idle(3);
    chk({14'h0, lko, rem}, 16'h0002);
    lkey = 1'b0;
    wr(ssr_pkg::CMD_REMOTE, 16'h0);
    idle(2);
    wr(ssr_pkg::CMD_LOCAL, 16'h0);
    idle(2);
    chk(ko, 16'ha5a5);
    summarize();
  end
endmodule : status_reporting_srq_logic_tb
`default_nettype wire

// ==== rtl/ssr_pkg.sv ====
// Purpose: Constants and types shared by the status reporting and service request logic.
// Assumes: One system clock; commands arrive already decoded from the bus parser.
// Notes: Bit positions follow the binary weights of each register (bit n has weight 2**n).
//
// Functional notes
// - Event bits latch and hold until cleared
// - Event query or clear-status clears that register
// - Reset command and device clear keep events
// - Event query returns binary weighted sum
// - Enable masks gate events into summary bit
// - Mask reads and clear-status keep masks
// - Status preset clears questionable enable mask
// - Status byte bits 3,4,5 follow their sources unlatched
// - Message flag set while output data waits
// - Status byte bits 3,4,5,6 used; others zero
// - Clear-status clears byte; query clears own bit
// - Byte mask clears on zero or power-on setting
// - Request service bit drives service request line
// - Serial poll or causing event read clears request
// - Serial poll returns byte, clears request only
// - Status byte query returns byte, clears nothing
// - Remote mode ignores all keys except local
// - Message flag timing depends on trigger mode
// - Standard event bit positions 0,2,3,4,5,7
// - Questionable bit positions 0,1,9,11,12

package ssr_pkg;

  // ---------------------------------------------------------------
  // Standard event register layout
  // ---------------------------------------------------------------
  localparam int unsigned ESR_OPC = 0;
  localparam int unsigned ESR_QRY = 2;
  localparam int unsigned ESR_DEV = 3;
  localparam int unsigned ESR_EXE = 4;
  localparam int unsigned ESR_CMD = 5;
  localparam int unsigned ESR_PON = 7;
  localparam logic [7:0] ESR_IMPL_MASK = 8'hbd;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ESE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Questionable data register layout
  // ---------------------------------------------------------------
  localparam int unsigned QUES_VOLT_OVL = 0;
  localparam int unsigned QUES_CURR_OVL = 1;
  localparam int unsigned QUES_OHM_OVL = 9;
  localparam int unsigned QUES_LIM_LO = 11;
  localparam int unsigned QUES_LIM_HI = 12;
  localparam logic [15:0] QUES_IMPL_MASK = 16'h1a03;
  localparam logic [15:0] QUES_OVL_MASK = 16'h0203;
  localparam logic [15:0] QUES_RESET = 16'h0000;
  localparam logic [15:0] QUES_EN_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Summary status byte layout
  // ---------------------------------------------------------------
  localparam int unsigned STB_QUES = 3;
  localparam int unsigned STB_MSG = 4;
  localparam int unsigned STB_ESB = 5;
  localparam int unsigned STB_RQS = 6;
  localparam logic [7:0] STB_SUM_MASK = 8'h38;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic PSC_RESET = 1'b1;

  // ---------------------------------------------------------------
  // Decoded commands and front panel modes
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_NOP = 5'h00, CMD_CLS = 5'h01, CMD_RST = 5'h02, CMD_DCL = 5'h03,
    CMD_ESR_Q = 5'h04, CMD_ESE_W = 5'h05, CMD_ESE_Q = 5'h06, CMD_SRE_W = 5'h07,
    CMD_SRE_Q = 5'h08, CMD_QEV_Q = 5'h09, CMD_QEN_W = 5'h0a, CMD_QEN_Q = 5'h0b,
    CMD_PRESET = 5'h0c, CMD_STB_Q = 5'h0d, CMD_PSC_W = 5'h0e, CMD_LOCAL = 5'h0f,
    CMD_REMOTE = 5'h10
  } ssr_cmd_e;

  typedef enum logic {
    PANEL_LOCAL = 1'b0,
    PANEL_REMOTE = 1'b1
  } ssr_panel_e;

  localparam logic MODE_IMMEDIATE = 1'b0;
  localparam logic MODE_STORED = 1'b1;

endpackage : ssr_pkg

// ==== rtl/ssr_status_core.sv ====
// Purpose: Status byte, event registers, enable masks, service request and panel lockout.
// Assumes: Commands come as one-cycle strobes with a decoded code; one command per cycle.
// Notes: Query answers are raw binary; the formatter turns them into decimal text.

`timescale 1ns/100ps
`default_nettype none

module ssr_status_core #(
  parameter int unsigned NUM_KEYS = 16,
  parameter int unsigned MSG_CNT_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Power cycle event (nonvolatile settings survive it)
  input wire logic power_on_evt,
  // Decoded command strobe
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_code,
  input wire logic [15:0] cmd_data,
  // Serial poll from bus interface hardware
  input wire logic serial_poll,
  // Instrument event pulses
  input wire logic opc_done,
  input wire logic query_err,
  input wire logic device_err,
  input wire logic exec_err,
  input wire logic command_err,
  input wire logic [15:0] ques_cond,
  // Output buffer traffic
  input wire logic trig_mode,
  input wire logic first_reading,
  input wire logic fetch_moved,
  input wire logic msg_loaded,
  input wire logic msg_read,
  // Front panel keys
  input wire logic [NUM_KEYS-1:0] keys_in,
  input wire logic local_key,
  // Query answer
  output logic resp_valid,
  output logic [15:0] resp_data,
  // Serial poll answer
  output logic poll_valid,
  output logic [7:0] poll_data,
  // Status byte and service request line
  output logic [7:0] status_byte,
  output logic srq_o,
  output logic srq_oe,
  output logic output_message_pending_flag,
  // Front panel
  output logic [NUM_KEYS-1:0] keys_out,
  output logic local_key_out,
  output logic remote_mode
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (NUM_KEYS < 1 || NUM_KEYS > 64) begin : g_chk_keys
    $error("NUM_KEYS must be between 1 and 64");
  end
  if (MSG_CNT_W < 1 || MSG_CNT_W > 16) begin : g_chk_cnt
    $error("MSG_CNT_W must be between 1 and 16");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Masked OR of an event register into one summary bit
  function automatic logic masked_any(input logic [15:0] ev, input logic [15:0] en);
    masked_any = |(ev & en);
  endfunction : masked_any

  // True for a command of the given code on this edge
  function automatic logic cmd_is(input logic v, input logic [4:0] c, input ssr_pkg::ssr_cmd_e k);
    cmd_is = v && (c == k);
  endfunction : cmd_is

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] esr_q;
  logic [7:0] ese_q;
  logic [15:0] ques_q;
  logic [15:0] ques_en_q;
  logic [7:0] sre_q;
  logic psc_q;
  logic [MSG_CNT_W-1:0] msg_cnt_q;
  logic rqs_q;
  logic req_cond_q;
  ssr_pkg::ssr_panel_e panel_q;
  logic do_cls;
  logic do_esr_q;
  logic do_qev_q;
  logic do_ese_w;
  logic do_sre_w;
  logic do_qen_w;
  logic do_preset;
  logic do_psc_w;
  logic do_dcl;
  logic [7:0] esr_set;
  logic [15:0] ques_set;
  logic [7:0] esr_d;
  logic [15:0] ques_d;
  logic msg_inc;
  logic msg_dec;
  logic msg_flush;
  logic msg_pending;
  logic ques_sum;
  logic esb_sum;
  logic [7:0] stb_d;
  logic req_cond;
  logic rqs_d;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // Reset and device clear have no effect on events or masks
  assign do_cls = cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_CLS);
  assign do_esr_q = cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_ESR_Q);
  assign do_qev_q = cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_QEV_Q);
  assign do_ese_w = cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_ESE_W);
  assign do_sre_w = cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_SRE_W);
  assign do_qen_w = cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_QEN_W);
  assign do_preset = cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_PRESET);
  assign do_psc_w = cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_PSC_W);
  assign do_dcl = cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_DCL);

  // ---------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------
  // Standard event set terms; overloads also count as device errors
  always_comb begin
    esr_set = 8'h00;
    esr_set[ssr_pkg::ESR_OPC] = opc_done;
    esr_set[ssr_pkg::ESR_QRY] = query_err | (msg_read && msg_cnt_q == '0);
    esr_set[ssr_pkg::ESR_DEV] = device_err | masked_any(ques_cond, ssr_pkg::QUES_OVL_MASK);
    esr_set[ssr_pkg::ESR_EXE] = exec_err;
    esr_set[ssr_pkg::ESR_CMD] = command_err;
    esr_set[ssr_pkg::ESR_PON] = power_on_evt;
    esr_set = esr_set & ssr_pkg::ESR_IMPL_MASK;
  end

  // Only documented questionable bits may ever set
  assign ques_set = ques_cond & ssr_pkg::QUES_IMPL_MASK;

  // Next values: a new event beats a clear in the same cycle
  assign esr_d = ((do_cls || do_esr_q) ? 8'h00 : esr_q) | esr_set;
  assign ques_d = ((do_cls || do_qev_q) ? 16'h0000 : ques_q) | ques_set;

  // ---------------------------------------------------------------
  // Event registers
  // ---------------------------------------------------------------
  // Standard event register, power-on bit set after a cold reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      esr_q <= ssr_pkg::ESR_RESET;
    end else begin
      esr_q <= esr_d;
    end
  end

  // Questionable data event register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ques_q <= ssr_pkg::QUES_RESET;
    end else begin
      ques_q <= ques_d;
    end
  end

  // ---------------------------------------------------------------
  // Enable masks and power-on-clear setting
  // ---------------------------------------------------------------
  // Standard event enable; writes and power-on clear only, clear-status leaves it alone
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ese_q <= ssr_pkg::ESE_RESET;
    end else if (power_on_evt && psc_q) begin
      ese_q <= 8'h00;
    end else if (do_ese_w) begin
      ese_q <= cmd_data[7:0] & ssr_pkg::ESR_IMPL_MASK;
    end
  end

  // Questionable enable; preset and power cycle clear it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ques_en_q <= ssr_pkg::QUES_EN_RESET;
    end else if (do_preset || power_on_evt) begin
      ques_en_q <= 16'h0000;
    end else if (do_qen_w) begin
      ques_en_q <= cmd_data & ssr_pkg::QUES_IMPL_MASK;
    end
  end

  // Status byte enable; kept across power cycle when setting is 0
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sre_q <= ssr_pkg::SRE_RESET;
    end else if (power_on_evt && psc_q) begin
      sre_q <= 8'h00;
    end else if (do_sre_w) begin
      sre_q <= cmd_data[7:0] & ssr_pkg::STB_SUM_MASK;
    end
  end

  // Power-on-clear setting
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      psc_q <= ssr_pkg::PSC_RESET;
    end else if (do_psc_w) begin
      psc_q <= cmd_data[0];
    end
  end

  // ---------------------------------------------------------------
  // Output buffer occupancy
  // ---------------------------------------------------------------
  // Readings count as a message only once the trigger mode allows it
  assign msg_inc = msg_loaded |
                   ((trig_mode == ssr_pkg::MODE_IMMEDIATE) && first_reading) |
                   ((trig_mode == ssr_pkg::MODE_STORED) && fetch_moved);
  assign msg_dec = msg_read && (msg_cnt_q != '0);
  assign msg_flush = do_dcl || do_cls;

  // Pending message counter, saturating at its top value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      msg_cnt_q <= '0;
    end else if (msg_flush) begin
      msg_cnt_q <= msg_inc ? MSG_CNT_W'(1) : '0;
    end else if (msg_inc && !msg_dec && msg_cnt_q != '1) begin
      msg_cnt_q <= msg_cnt_q + MSG_CNT_W'(1);
    end else if (msg_dec && !msg_inc) begin
      msg_cnt_q <= msg_cnt_q - MSG_CNT_W'(1);
    end
  end

  assign msg_pending = (msg_cnt_q != '0);

  // ---------------------------------------------------------------
  // Summary status byte
  // ---------------------------------------------------------------
  // Summaries follow the next event values, so a clear shows at once
  assign ques_sum = masked_any(ques_d, ques_en_q);
  assign esb_sum = masked_any({8'h00, esr_d}, {8'h00, ese_q});

  // Unused bits stay zero
  always_comb begin
    stb_d = 8'h00;
    stb_d[ssr_pkg::STB_QUES] = ques_sum;
    stb_d[ssr_pkg::STB_MSG] = msg_pending;
    stb_d[ssr_pkg::STB_ESB] = esb_sum;
    stb_d[ssr_pkg::STB_RQS] = rqs_d;
  end

  // ---------------------------------------------------------------
  // Request service
  // ---------------------------------------------------------------
  // Any enabled summary bit asks for service
  assign req_cond = |({2'b00, esb_sum, msg_pending, ques_sum, 3'b000} & sre_q);

  // Set on a rising request, cleared by poll or when its cause is read away
  always_comb begin
    if (req_cond && !req_cond_q) begin
      rqs_d = 1'b1;
    end else if (serial_poll || !req_cond || do_cls) begin
      rqs_d = 1'b0;
    end else begin
      rqs_d = rqs_q;
    end
  end

  // Request flag and condition history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rqs_q <= 1'b0;
      req_cond_q <= 1'b0;
    end else begin
      rqs_q <= rqs_d;
      req_cond_q <= req_cond;
    end
  end

  // Registered status byte and service request drive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_byte <= 8'h00;
      srq_oe <= 1'b0;
      srq_o <= 1'b0;
      output_message_pending_flag <= 1'b0;
    end else begin
      status_byte <= stb_d;
      srq_oe <= rqs_d;
      srq_o <= 1'b0;
      output_message_pending_flag <= msg_pending;
    end
  end

  // ---------------------------------------------------------------
  // Serial poll answer
  // ---------------------------------------------------------------
  // Poll sees the byte with the request bit before it drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      poll_valid <= 1'b0;
      poll_data <= 8'h00;
    end else begin
      poll_valid <= serial_poll;
      if (serial_poll) begin
        poll_data <= {1'b0, rqs_q, stb_d[5:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Query answers
  // ---------------------------------------------------------------
  // Registers read as plain binary weighted values
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_data <= 16'h0000;
    end else begin
      resp_valid <= 1'b0;
      if (cmd_valid) begin
        case (cmd_code)
          ssr_pkg::CMD_ESR_Q: begin
            resp_valid <= 1'b1;
            resp_data <= {8'h00, esr_q};
          end
          ssr_pkg::CMD_QEV_Q: begin
            resp_valid <= 1'b1;
            resp_data <= ques_q;
          end
          ssr_pkg::CMD_ESE_Q: begin
            resp_valid <= 1'b1;
            resp_data <= {8'h00, ese_q};
          end
          ssr_pkg::CMD_QEN_Q: begin
            resp_valid <= 1'b1;
            resp_data <= ques_en_q;
          end
          ssr_pkg::CMD_SRE_Q: begin
            resp_valid <= 1'b1;
            resp_data <= {8'h00, sre_q};
          end
          ssr_pkg::CMD_STB_Q: begin
            resp_valid <= 1'b1;
            resp_data <= {8'h00, 1'b0, rqs_q, stb_d[5:0]};
          end
          default: begin
            resp_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Front panel lockout
  // ---------------------------------------------------------------
  // Mode follows remote and local commands and the local key
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      panel_q <= ssr_pkg::PANEL_LOCAL;
    end else begin
      case (panel_q)
        ssr_pkg::PANEL_LOCAL: begin
          if (cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_REMOTE)) begin
            panel_q <= ssr_pkg::PANEL_REMOTE;
          end
        end
        ssr_pkg::PANEL_REMOTE: begin
          if (local_key || cmd_is(cmd_valid, cmd_code, ssr_pkg::CMD_LOCAL)) begin
            panel_q <= ssr_pkg::PANEL_LOCAL;
          end
        end
        default: begin
          panel_q <= ssr_pkg::PANEL_LOCAL;
        end
      endcase
    end
  end

  // Keys pass only in local mode; the local key always passes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keys_out <= '0;
      local_key_out <= 1'b0;
      remote_mode <= 1'b0;
    end else begin
      keys_out <= (panel_q == ssr_pkg::PANEL_REMOTE) ? '0 : keys_in;
      local_key_out <= local_key;
      remote_mode <= (panel_q == ssr_pkg::PANEL_REMOTE);
    end
  end

endmodule : ssr_status_core

`default_nettype wire
